// file: acd_pkg.sv
// Package for the converter result and reference DAC control block
package acd_pkg;
   localparam int ACD_AW = 3;
   localparam logic [2:0] ADDR_CTRL0 = 3'h0;
   localparam logic [2:0] ADDR_CTRL1 = 3'h1;
   localparam logic [2:0] ADDR_CTRL2 = 3'h2;
   localparam logic [2:0] ADDR_RES_HI = 3'h3;
   localparam logic [2:0] ADDR_RES_LO = 3'h4;
   localparam logic [2:0] ADDR_DAC0 = 3'h5;
   localparam logic [2:0] ADDR_DAC1 = 3'h6;
   localparam logic [2:0] ADDR_PORT = 3'h7;
   localparam int CTRL0_GO_BIT = 1;
   localparam int CTRL0_ON_BIT = 0;
   localparam int CTRL1_JUSTIFY_BIT = 7;
   localparam int DAC0_EN_BIT = 7;
   localparam int DAC0_OE_BIT = 5;
   localparam logic [7:0] CTRL0_MASK = 8'h7f;
   localparam logic [7:0] CTRL1_MASK = 8'hf3;
   localparam logic [7:0] CTRL2_MASK = 8'hf8;
   localparam logic [7:0] DAC0_MASK = 8'hac;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int CONV_CYCLES = 12;
   typedef struct packed {
      logic [ACD_AW-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } acd_bus_s;
endpackage

// file: acd_result_fmt.sv
// Result formatter: turns a 10-bit conversion value into two result bytes
`timescale 1ns/1ns
module acd_result_fmt
   import acd_pkg::*;
(
   input wire logic [9:0] value_in,
   input wire logic right_in,
   output logic [7:0] high_out,
   output logic [7:0] low_out
);
   assign high_out = right_in ? {6'h00, value_in[9:8]} : value_in[9:2];
   assign low_out = right_in ? value_in[7:0] : {value_in[1:0], 6'h00};
endmodule

// file: acd_top.sv
// Converter result formatting and reference DAC control
`timescale 1ns/1ns
module acd_top
   import acd_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
)(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire acd_bus_s bus_in,
   input wire logic [9:0] sample_in,
   input wire logic dac_pin_in,
   output logic [7:0] rdata_out,
   output logic conv_busy_out,
   output logic dac_on_out,
   output logic [7:0] dac_level_out,
   output logic dac_pin_route_out,
   output logic dig_drv_off_out,
   output logic [4:0] channel_out
);
   logic [7:0] ctrl0;
   logic [7:0] ctrl1;
   logic [7:0] ctrl2;
   logic [7:0] res_hi;
   logic [7:0] res_lo;
   logic [7:0] dac0;
   logic [7:0] dac1;
   logic [7:0] conv_cnt;
   logic [2:0] pin_sync;
   logic pin_level;
   logic [7:0] next_rdata;
   wire wr_ctrl0 = bus_in.wr && bus_in.addr == ADDR_CTRL0;
   wire wr_ctrl1 = bus_in.wr && bus_in.addr == ADDR_CTRL1;
   wire wr_ctrl2 = bus_in.wr && bus_in.addr == ADDR_CTRL2;
   wire wr_hi = bus_in.wr && bus_in.addr == ADDR_RES_HI;
   wire wr_lo = bus_in.wr && bus_in.addr == ADDR_RES_LO;
   wire wr_dac0 = bus_in.wr && bus_in.addr == ADDR_DAC0;
   wire wr_dac1 = bus_in.wr && bus_in.addr == ADDR_DAC1;
   wire busy = ctrl0[CTRL0_GO_BIT];
   wire powered = ctrl0[CTRL0_ON_BIT];
   wire done = busy && conv_cnt == 8'(CONV_LEN - 1);
   wire pin_dac_mode = dac0[DAC0_OE_BIT];
   wire [7:0] fmt_hi;
   wire [7:0] fmt_lo;
   // Port bit reads zero in DAC output mode
   wire port_bit = pin_dac_mode ? 1'b0 : pin_level;
   // Holds the written value with bit 7 cleared, but start needs converter power
   wire [7:0] ctrl0_wval = {bus_in.wdata[7:2] , bus_in.wdata[1] & bus_in.wdata[0],
      bus_in.wdata[0]} & CTRL0_MASK;

   acd_result_fmt u_fmt (
      .value_in(sample_in),
      .right_in(ctrl1[CTRL1_JUSTIFY_BIT]),
      .high_out(fmt_hi),
      .low_out(fmt_lo)
   );

   always_comb begin
      next_rdata = RESET_BYTE;
      unique case (bus_in.addr)
         ADDR_CTRL0: next_rdata = ctrl0;
         ADDR_CTRL1: next_rdata = ctrl1;
         ADDR_CTRL2: next_rdata = ctrl2;
         ADDR_RES_HI: next_rdata = res_hi;
         ADDR_RES_LO: next_rdata = res_lo;
         ADDR_DAC0: next_rdata = dac0;
         ADDR_DAC1: next_rdata = dac1;
         ADDR_PORT: next_rdata = {7'h00, port_bit};
      endcase
   end

   // Pin input passes three flops; a change counts once stages two and three agree
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_sync <= 3'h0;
         pin_level <= 1'b0;
      end else if (ce_in) begin
         pin_sync <= {pin_sync[1:0], dac_pin_in};
         if (pin_sync[2] == pin_sync[1]) begin
            pin_level <= pin_sync[2];
         end
      end
   end

   // Software sets go; hardware clears on completion
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl0 <= RESET_BYTE;
      end else if (ce_in) begin
         if (wr_ctrl0) begin
            ctrl0 <= ctrl0_wval;
         end else if (done || !powered) begin
            ctrl0[CTRL0_GO_BIT] <= 1'b0;
         end
      end
   end

   // The count only runs while a conversion is in flight
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         conv_cnt <= 8'h00;
      end else if (ce_in) begin
         conv_cnt <= (busy && !done) ? conv_cnt + 8'h01 : 8'h00;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl1 <= RESET_BYTE;
         ctrl2 <= RESET_BYTE;
      end else if (ce_in) begin
         if (wr_ctrl1) begin
            ctrl1 <= bus_in.wdata & CTRL1_MASK;
         end
         if (wr_ctrl2) begin
            ctrl2 <= bus_in.wdata & CTRL2_MASK;
         end
      end
   end

   // Both bytes load in the completion cycle; completion beats a write
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         res_hi <= RESET_BYTE;
         res_lo <= RESET_BYTE;
      end else if (ce_in) begin
         if (done) begin
            res_hi <= fmt_hi;
            res_lo <= fmt_lo;
         end else begin
            if (wr_hi) begin
               res_hi <= bus_in.wdata;
            end
            if (wr_lo) begin
               res_lo <= bus_in.wdata;
            end
         end
      end
   end

   // Reset clears DAC control; only bus writes change it otherwise
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dac0 <= RESET_BYTE;
         dac1 <= RESET_BYTE;
      end else if (ce_in) begin
         if (wr_dac0) begin
            dac0 <= bus_in.wdata & DAC0_MASK;
         end
         if (wr_dac1) begin
            dac1 <= bus_in.wdata;
         end
      end
   end

   // Outputs registered one cycle behind the control state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= RESET_BYTE;
         conv_busy_out <= 1'b0;
         dac_on_out <= 1'b0;
         dac_level_out <= RESET_BYTE;
         dac_pin_route_out <= 1'b0;
         dig_drv_off_out <= 1'b0;
         channel_out <= 5'h00;
      end else if (ce_in) begin
         rdata_out <= bus_in.rd ? next_rdata : RESET_BYTE;
         conv_busy_out <= busy;
         // DAC runs only with enable bit
         dac_on_out <= dac0[DAC0_EN_BIT];
         dac_level_out <= dac1;
         dac_pin_route_out <= pin_dac_mode;
         dig_drv_off_out <= pin_dac_mode;
         channel_out <= ctrl0[6:2];
      end
   end

   chk_go_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && done && !wr_ctrl0) |=> !busy)
      else $error("go flag not cleared at completion");
   chk_result_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && done) |=> (res_hi == $past(fmt_hi) && res_lo == $past(fmt_lo)))
      else $error("result bytes not loaded together");
   chk_right_hi: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && done && ctrl1[CTRL1_JUSTIFY_BIT]) |=> res_hi[7:2] == 6'h00)
      else $error("upper bits not zero");
   chk_right_val: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && done && ctrl1[CTRL1_JUSTIFY_BIT]) |=>
      {res_hi[1:0], res_lo} == $past(sample_in))
      else $error("right justified value wrong");
   chk_left_val: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && done && !ctrl1[CTRL1_JUSTIFY_BIT]) |=>
      ({res_hi, res_lo[7:6]} == $past(sample_in) && res_lo[5:0] == 6'h00))
      else $error("left justified value wrong");
   chk_dac_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in |=> dac_on_out == $past(dac0[DAC0_EN_BIT]))
      else $error("dac enable mismatch");
   // The output stage only moves if the enable was high on the edge after the write
   chk_dac_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && wr_dac1) ##1 ce_in |=> dac_level_out == $past(bus_in.wdata, 2))
      else $error("dac level mismatch");
   chk_pin_route: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in |=> dac_pin_route_out == $past(dac0[DAC0_OE_BIT]))
      else $error("pin route does not follow output enable");
   chk_drv_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in |=> dig_drv_off_out == $past(dac0[DAC0_OE_BIT]))
      else $error("digital driver not disabled with dac pin");
   chk_level_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !(ce_in && wr_dac1) |=> $stable(dac1))
      else $error("dac level code changed without write");
   chk_port_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && bus_in.rd && bus_in.addr == ADDR_PORT && !pin_dac_mode) |=>
      rdata_out == {7'h00, $past(pin_level)})
      else $error("port bit does not show pin level");
   chk_go_power: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !wr_ctrl0 && !powered) |=> !busy)
      else $error("go flag set with converter off");
   // Software must never see one byte of a new result beside one of the old
   chk_result_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !(ce_in && (done || wr_hi || wr_lo)) |=> $stable({res_hi, res_lo}))
      else $error("result bytes changed without load or write");
   chk_rdata_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !bus_in.rd) |=> rdata_out == 8'h00)
      else $error("read data not idle after a non-read cycle");
   // Checked a cycle in, once the asynchronous clear has settled
   chk_reset_clear: assert property (@(posedge clk_in)
      (!rst_n_in ##1 !rst_n_in) |-> (dac0 == RESET_BYTE && dac1 == RESET_BYTE
      && !dac_on_out && !dac_pin_route_out && dac_level_out == RESET_BYTE))
      else $error("dac state not cleared by reset");
   chk_port_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && bus_in.rd && bus_in.addr == ADDR_PORT && pin_dac_mode) |=> rdata_out == 8'h00)
      else $error("port bit not zero in dac mode");
   chk_dac_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !(ce_in && wr_dac0) |=> $stable(dac0))
      else $error("dac control changed without write");
   cov_conv_done: cover property (@(posedge clk_in) disable iff (!rst_n_in) ce_in && done);
   cov_dac_pin: cover property (@(posedge clk_in) disable iff (!rst_n_in) dac_pin_route_out);
   cov_port_read: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      bus_in.rd && bus_in.addr == ADDR_PORT);
   cov_left_done: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && done && !ctrl1[CTRL1_JUSTIFY_BIT]);
   cov_frozen_wr: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      !ce_in && bus_in.wr);
endmodule

// file: tb_acd_top.sv
// Self-checking bench for the converter result and DAC control block
`timescale 1ns/1ns
module tb_acd_top
   import acd_pkg::*;
;
   localparam int LEN = 5;
   localparam int ACQ = 8;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce_in = 1'b1;
   acd_bus_s bus_in = '0;
   logic [9:0] sample_in = 10'h000;
   logic dac_pin_in = 1'b0;
   logic [7:0] rdata_out;
   logic [7:0] dac_level_out;
   logic conv_busy_out;
   logic dac_on_out;
   logic dac_pin_route_out;
   logic dig_drv_off_out;
   logic [4:0] channel_out;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int i;
   int k;
   int n;
   int m;
   logic [7:0] d;
   logic [7:0] v;
   logic [7:0] w;
   logic [9:0] s;
   logic [4:0] ch;
   logic [15:0] e;

   acd_top #(.CONV_LEN(LEN)) acd_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .bus_in(bus_in), .sample_in(sample_in), .dac_pin_in(dac_pin_in), .rdata_out(rdata_out),
      .conv_busy_out(conv_busy_out), .dac_on_out(dac_on_out), .dac_level_out(dac_level_out),
      .dac_pin_route_out(dac_pin_route_out), .dig_drv_off_out(dig_drv_off_out),
      .channel_out(channel_out));

   always #50 clk_in = ~clk_in;

   // Expected result bytes for either justification
   function automatic logic [15:0] fmt(input logic [9:0] x, input logic right);
      return right ? {6'h00, x[9:8], x[7:0]} : {x[9:2], x[1:0], 6'h00};
   endfunction

   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] x);
      @(posedge clk_in);
      bus_in <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus_in.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] x);
      @(posedge clk_in);
      bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus_in.rd <= 1'b0;
      @(negedge clk_in);
      x = rdata_out;
      @(negedge clk_in);
      chk(rdata_out, 8'h00);
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         wrap_up();
      end
   end

   initial begin
      i = $urandom(38771);
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 8; i++) begin
         rd(i[2:0], d);
         chk(d, RESET_BYTE);
      end
      chk({dac_on_out, dac_pin_route_out, dig_drv_off_out, conv_busy_out, 4'h0}, 8'h00);
      // Readback through the write masks, result bytes written by software
      for (k = 0; k < 4; k++) begin
         w = (k == 0) ? 8'hff : 8'($urandom);
         wr(ADDR_CTRL1, w);
         wr(ADDR_CTRL2, ~w);
         rd(ADDR_CTRL1, d);
         chk(d, w & CTRL1_MASK);
         rd(ADDR_CTRL2, d);
         chk(d, ~w & CTRL2_MASK);
         wr(ADDR_RES_HI, w);
         wr(ADDR_RES_LO, ~w);
         rd(ADDR_RES_HI, d);
         chk(d, w);
         rd(ADDR_RES_LO, d);
         chk(d, ~w);
      end
      for (k = 0; k < 6; k++) begin
         v = (k < 2) ? {k[0], 1'b0, k[0], 5'h00} : 8'($urandom);
         w = (k < 2) ? {8{k[0]}} : 8'($urandom);
         dac_pin_in <= (k < 2) ? 1'b1 : 1'($urandom);
         wr(ADDR_DAC0, v);
         wr(ADDR_DAC1, w);
         repeat (4) @(negedge clk_in);
         chk({7'h00, dac_on_out}, {7'h00, v[7]});
         chk(dac_level_out, w);
         chk({6'h00, dac_pin_route_out, dig_drv_off_out}, {6'h00, v[5], v[5]});
         rd(ADDR_PORT, d);
         chk(d, {7'h00, dac_pin_in & ~v[5]});
      end
      // Sleep stand-in: DAC switched off first, then the clock enable dropped
      v = v & 8'h7f;
      wr(ADDR_DAC0, v);
      ce_in <= 1'b0;
      wr(ADDR_DAC1, ~w);
      wr(ADDR_DAC0, 8'hff);
      ce_in <= 1'b1;
      rd(ADDR_DAC1, d);
      chk(d, w);
      rd(ADDR_DAC0, d);
      chk(d, v & DAC0_MASK);
      for (k = 0; k < 8; k++) begin
         s = (k < 2) ? 10'h3ff : 10'($urandom);
         ch = 5'($urandom);
         e = fmt(s, k[0]);
         wr(ADDR_CTRL1, {k[0], 7'h00});
         sample_in <= s;
         wr(ADDR_CTRL0, {1'b0, ch, 2'b01});
         // Channel settles for an acquisition interval before go
         repeat (ACQ) @(posedge clk_in);
         wr(ADDR_CTRL0, {1'b0, ch, 2'b11});
         n = 0;
         while (conv_busy_out !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
         end
         m = 0;
         while (conv_busy_out !== 1'b0 && m < 60) begin
            @(negedge clk_in);
            m++;
         end
         chk(8'(m), 8'(LEN));
         chk({3'h0, channel_out}, {3'h0, ch});
         rd(ADDR_CTRL0, d);
         chk(d, {1'b0, ch, 2'b01});
         rd(ADDR_RES_HI, d);
         chk(d, e[15:8]);
         rd(ADDR_RES_LO, d);
         chk(d, e[7:0]);
      end
      rd(ADDR_DAC0, d);
      chk(d, v & DAC0_MASK);
      wr(ADDR_DAC0, 8'ha0);
      wr(ADDR_DAC1, 8'h5a);
      repeat (2) @(negedge clk_in);
      chk({dac_on_out, dac_pin_route_out, 6'h00}, 8'hc0);
      // Reset in mid-run clears the DAC state
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(negedge clk_in);
      chk({dac_on_out, dac_pin_route_out, dig_drv_off_out, 5'h00}, 8'h00);
      chk(dac_level_out, 8'h00);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(ADDR_DAC1, d);
      chk(d, 8'h00);
      rd(ADDR_DAC0, d);
      chk(d, 8'h00);
      wrap_up();
   end
endmodule
